// [shared/lmsc_pkg.sv]
// lmsc_pkg: register map, fields, reset values, ranges and timing of the load setpoint control
package lmsc_pkg;

   // register byte offsets
   localparam logic [5:0] LMSC_OFF_CTRL = 6'h00;
   localparam logic [5:0] LMSC_OFF_MODE = 6'h04;
   localparam logic [5:0] LMSC_OFF_SETPT = 6'h08;
   localparam logic [5:0] LMSC_OFF_TRIG = 6'h0c;
   localparam logic [5:0] LMSC_OFF_TRAN_HI = 6'h10;
   localparam logic [5:0] LMSC_OFF_TRAN_LO = 6'h14;
   localparam logic [5:0] LMSC_OFF_DWELL_HI = 6'h18;
   localparam logic [5:0] LMSC_OFF_DWELL_LO = 6'h1c;
   localparam logic [5:0] LMSC_OFF_LIM = 6'h20;
   localparam logic [5:0] LMSC_OFF_LIM_DLY = 6'h24;
   localparam logic [5:0] LMSC_OFF_STATUS = 6'h28;
   localparam logic [5:0] LMSC_OFF_TARGET = 6'h2c;
   localparam logic [5:0] LMSC_OFF_IRQ_STAT = 6'h30;
   localparam logic [5:0] LMSC_OFF_IRQ_MASK = 6'h34;
   localparam logic [5:0] LMSC_OFF_CMD = 6'h38;

   // field positions
   localparam int LMSC_CTRL_ON_BIT = 0;
   localparam int LMSC_CTRL_TRAN_BIT = 1;
   localparam int LMSC_MODE_VR_BIT = 4;
   localparam int LMSC_CMD_REMOTE_BIT = 0;
   localparam int LMSC_CMD_LOCAL_BIT = 1;
   localparam int LMSC_EV_TRIP = 0;
   localparam int LMSC_EV_FORCED_OFF = 1;
   localparam int LMSC_EV_TRIG = 2;
   localparam int LMSC_EV_CTRL = 3;

   // reset values
   localparam logic [15:0] LMSC_SETPT_RST = 16'h0000;
   localparam logic [15:0] LMSC_LIM_RST = 16'hffff;
   localparam logic [15:0] LMSC_LIM_DLY_RST = 16'h0001;
   localparam logic [16:0] LMSC_DWELL_RST = 17'h00001;

   // timing: one millisecond base at the system clock rate
   localparam int LMSC_CLK_PERIOD_NS = 100;
   localparam int LMSC_MS_NS = 1000000;
   localparam int LMSC_MS_CYCLES = LMSC_MS_NS / LMSC_CLK_PERIOD_NS;
   localparam logic [15:0] LMSC_LIM_DLY_MIN_MS = 16'h0001;   // 0.001 s
   localparam logic [15:0] LMSC_LIM_DLY_MAX_MS = 16'hea60;   // 60 s
   localparam logic [16:0] LMSC_DWELL_MAX_MS = 17'h1869f;    // 99999 ms
   localparam int LMSC_CR_SHIFT = 8;                         // current scale of v/r

   // nine test modes
   typedef enum logic [3:0] {
      current_low_range,
      current_high_range,
      voltage_mode_low_range,
      voltage_mode_high_range,
      resistance_low_range,
      resistance_medium_range,
      resistance_high_range,
      power_voltage_source_mode,
      power_current_source_mode
   } lmsc_mode_t;
   localparam logic [3:0] LMSC_NUM_MODES = 4'h9;

   // voltage range for resistance modes
   localparam logic low_voltage_range = 1'b0;
   localparam logic high_voltage_range = 1'b1;

   // setting range limits, plain defaults in device units
   localparam logic [15:0] LMSC_MIN_LEVEL = 16'h0000;
   localparam logic [15:0] LMSC_MIN_RES = 16'h0001;
   localparam logic [15:0] LMSC_MAX_CUR_LO = 16'h0bb8;
   localparam logic [15:0] LMSC_MAX_CUR_HI = 16'h7530;
   localparam logic [15:0] LMSC_MAX_VOLT_LO = 16'h1770;
   localparam logic [15:0] LMSC_MAX_VOLT_HI = 16'h3a98;
   localparam logic [15:0] LMSC_MAX_RES_LO = 16'h05dc;
   localparam logic [15:0] LMSC_MAX_RES_MED = 16'h2710;
   localparam logic [15:0] LMSC_MAX_RES_HI = 16'hea60;
   localparam logic [15:0] LMSC_VH_RES_STEP = 16'h0002;      // high voltage range span factor
   localparam logic [15:0] LMSC_MAX_POW_V = 16'h4e20;
   localparam logic [15:0] LMSC_MAX_POW_C = 16'h4e20;

   function automatic logic [15:0] lmsc_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic lmsc_is_res(input lmsc_mode_t m);
      return (m == resistance_low_range) || (m == resistance_medium_range) ||
             (m == resistance_high_range);
   endfunction

   function automatic logic [15:0] lmsc_min(input lmsc_mode_t m, input logic vr);
      return lmsc_is_res(m) ? LMSC_MIN_RES : LMSC_MIN_LEVEL;
   endfunction

   function automatic logic [15:0] lmsc_max(input lmsc_mode_t m, input logic vr);
      logic [15:0] r;
      r = LMSC_MAX_POW_C;
      case (m)
         current_low_range: r = LMSC_MAX_CUR_LO;
         current_high_range: r = LMSC_MAX_CUR_HI;
         voltage_mode_low_range: r = LMSC_MAX_VOLT_LO;
         voltage_mode_high_range: r = LMSC_MAX_VOLT_HI;
         resistance_low_range: r = LMSC_MAX_RES_LO;
         resistance_medium_range: r = LMSC_MAX_RES_MED;
         resistance_high_range: r = LMSC_MAX_RES_HI;
         power_voltage_source_mode: r = LMSC_MAX_POW_V;
         default: r = LMSC_MAX_POW_C;
      endcase
      if (lmsc_is_res(m) && vr == high_voltage_range && m != resistance_high_range) begin
         r = 16'(r * LMSC_VH_RES_STEP);
      end
      return r;
   endfunction

endpackage

// [src/lmsc_top.sv]
// lmsc_top: mode, setpoint, trigger, transient and current-limit control of the load
//
// How it works
// - after reset the block is in local control, panel accepted
// - a remote command write puts the block into remote control at once
// - in remote the indicator is lit and panel writes are ignored
// - local command write or long lock key press returns to local, indicator off
// - nine test modes are held until explicitly changed
// - changing mode while input is on switches the input off
// - switching the input on applies the stored set value one cycle later
// - out of range set values are clamped to range minimum or maximum
// - current mode has a low and a high range with different spans
// - current range change switches input off and refits the setpoint
// - a trigger copies the triggered level into the immediate level
// - after one applied trigger, further triggers wait for a new level write
// - transient enable alternates the active level between upper and lower in current, voltage and resistance modes
// - current above limit for longer than the delay trips input off, alarm
// - resistance mode has three sub-ranges in each of two voltage ranges
// - in resistance mode the sink target is input voltage over resistance
// - transient dwell times are programmable from 0 to 99999 ms
`timescale 1ns/100ps
module lmsc_top import lmsc_pkg::*; #(
   parameter int unsigned MS_CYCLES = LMSC_MS_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // avalon-mm slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // front panel (keys and knob, decoded to register writes)
   input wire logic panel_wr_i,
   input wire logic [5:0] panel_addr_i,
   input wire logic [31:0] panel_wdata_i,
   output logic panel_ready_o,
   input wire logic panel_lock_long_i,
   // trigger and measurements
   input wire logic trig_i,
   input wire logic [15:0] meas_cur_i,
   input wire logic [15:0] meas_volt_i,
   // load control and indicators
   output logic input_on_o,
   output logic [15:0] sink_target_o,
   output logic remote_indicator_o,
   output logic alarm_o,
   output logic irq_o
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic remote;
      logic input_on;
      logic tran_en;
      lmsc_mode_t mode;
      logic vrange;
      logic [15:0] setpt;
      logic [15:0] trig_lvl;
      logic trig_pend;
      logic [15:0] tran_hi;
      logic [15:0] tran_lo;
      logic [16:0] dwell_hi;
      logic [16:0] dwell_lo;
      logic [15:0] lim;
      logic [15:0] lim_dly;
      logic tran_phase;
      logic [16:0] tran_ms;
      logic [15:0] lim_ms;
      logic [23:0] ms_div;
      logic alarm;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [15:0] target;
   } lmsc_state_t;

   lmsc_state_t st_reg;
   lmsc_state_t st_next;

   logic bus_take;
   logic bus_wr_take;
   logic panel_take;
   logic ms_tick;
   logic tran_act;
   logic over_lim;
   logic [16:0] dwell_cur;
   logic [15:0] level_cur;

   // resistance mode sink current: scaled v / r, saturated to the output width
   function automatic logic [15:0] cr_current(input logic [15:0] v, input logic [15:0] r);
      logic [23:0] q;
      q = {v, 8'h00} / {8'h00, r};
      return (q[23:16] != 8'h00) ? 16'hffff : q[15:0];
   endfunction

   // transient is meaningful only in current, voltage and resistance modes
   function automatic logic tran_mode_ok(input lmsc_mode_t m);
      return (m != power_voltage_source_mode) && (m != power_current_source_mode);
   endfunction

   // registers the front panel may reach; command and interrupt registers are bus only
   function automatic logic panel_ok(input logic [5:0] a);
      return (a != LMSC_OFF_CMD) && (a != LMSC_OFF_IRQ_STAT) && (a != LMSC_OFF_IRQ_MASK);
   endfunction

   // one register write, shared by the bus and the front panel
   function automatic lmsc_state_t apply_write(input lmsc_state_t s, input logic [5:0] a,
                                               input logic [31:0] d);
      lmsc_state_t r;
      lmsc_mode_t nm;
      r = s;
      nm = lmsc_mode_t'(d[3:0]);
      case (a)
         LMSC_OFF_CTRL: begin
            if (d[LMSC_CTRL_ON_BIT] && !s.input_on) begin
               r.alarm = 1'b0;      // a new turn-on clears the trip alarm
            end
            r.input_on = d[LMSC_CTRL_ON_BIT];
            r.tran_en = d[LMSC_CTRL_TRAN_BIT];
         end
         LMSC_OFF_MODE: begin
            // unknown mode codes are dropped so the held mode stays valid
            if (d[3:0] < LMSC_NUM_MODES && (nm != s.mode || d[LMSC_MODE_VR_BIT] != s.vrange)) begin
               if (s.input_on) begin
                  r.irq_stat[LMSC_EV_FORCED_OFF] = 1'b1;
               end
               r.input_on = 1'b0;
               r.mode = nm;
               r.vrange = d[LMSC_MODE_VR_BIT];
               r.setpt = lmsc_clamp(s.setpt, lmsc_min(nm, r.vrange),
                                    lmsc_max(nm, r.vrange));
               r.tran_hi = lmsc_clamp(s.tran_hi, lmsc_min(nm, r.vrange), lmsc_max(nm, r.vrange));
               r.tran_lo = lmsc_clamp(s.tran_lo, lmsc_min(nm, r.vrange), lmsc_max(nm, r.vrange));
            end
         end
         LMSC_OFF_SETPT: begin
            r.setpt = lmsc_clamp(d[15:0], lmsc_min(s.mode, s.vrange),
                                 lmsc_max(s.mode, s.vrange));
         end
         LMSC_OFF_TRIG: begin
            r.trig_lvl = d[15:0];
            r.trig_pend = 1'b1;
         end
         LMSC_OFF_TRAN_HI: begin
            r.tran_hi = lmsc_clamp(d[15:0], lmsc_min(s.mode, s.vrange), lmsc_max(s.mode, s.vrange));
         end
         LMSC_OFF_TRAN_LO: begin
            r.tran_lo = lmsc_clamp(d[15:0], lmsc_min(s.mode, s.vrange), lmsc_max(s.mode, s.vrange));
         end
         LMSC_OFF_DWELL_HI: begin
            r.dwell_hi = (d[16:0] > LMSC_DWELL_MAX_MS) ? LMSC_DWELL_MAX_MS : d[16:0];
         end
         LMSC_OFF_DWELL_LO: begin
            r.dwell_lo = (d[16:0] > LMSC_DWELL_MAX_MS) ? LMSC_DWELL_MAX_MS : d[16:0];
         end
         LMSC_OFF_LIM: begin
            r.lim = d[15:0];
         end
         LMSC_OFF_LIM_DLY: begin
            r.lim_dly = lmsc_clamp(d[15:0], LMSC_LIM_DLY_MIN_MS, LMSC_LIM_DLY_MAX_MS);
         end
         LMSC_OFF_IRQ_MASK: begin
            r.irq_mask = d[3:0];
         end
         LMSC_OFF_IRQ_STAT: begin
            r.irq_stat = s.irq_stat & ~d[3:0];   // events later in the cycle set again
         end
         LMSC_OFF_CMD: begin
            if (d[LMSC_CMD_REMOTE_BIT] && !s.remote) begin
               r.remote = 1'b1;
               r.irq_stat[LMSC_EV_CTRL] = 1'b1;
            end else if (d[LMSC_CMD_LOCAL_BIT] && s.remote) begin
               r.remote = 1'b0;
               r.irq_stat[LMSC_EV_CTRL] = 1'b1;
            end
         end
         default: begin
            r = s;               // unmapped or read-only: write ignored
         end
      endcase
      return r;
   endfunction

   // request decode; one wait cycle, answer on the second edge
   assign bus_take = (avs_read_i || avs_write_i) && st_reg.ack;
   assign bus_wr_take = avs_write_i && st_reg.ack;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_reg.ack;
   // a panel write collides with a bus write; the panel is stalled rather than lost
   assign panel_ready_o = !bus_wr_take;
   assign panel_take = panel_wr_i && !bus_wr_take && !st_reg.remote && panel_ok(panel_addr_i);
   assign ms_tick = (st_reg.ms_div == 24'(MS_CYCLES - 1));
   assign tran_act = st_reg.tran_en && st_reg.input_on && tran_mode_ok(st_reg.mode);
   assign dwell_cur = st_reg.tran_phase ? st_reg.dwell_hi : st_reg.dwell_lo;
   assign over_lim = st_reg.input_on && (meas_cur_i > st_reg.lim);
   assign level_cur = tran_act ? (st_reg.tran_phase ? st_reg.tran_hi : st_reg.tran_lo) :
                      st_reg.setpt;

   // next-state logic for the whole block
   always_comb begin
      st_next = st_reg;

      // millisecond base shared by transient dwell and limit delay
      st_next.ms_div = ms_tick ? 24'h000000 : 24'(st_reg.ms_div + 24'h000001);

      // bus slave: latch read data on the first cycle, act on the answering edge
      if (st_reg.ack) begin
         st_next.ack = 1'b0;
         if (bus_wr_take) begin
            st_next = apply_write(st_next, avs_address_i, avs_writedata_i);
         end
      end else if (avs_read_i || avs_write_i) begin
         st_next.ack = 1'b1;
         case (avs_address_i)
            LMSC_OFF_CTRL: st_next.rdata = {30'h0, st_reg.tran_en, st_reg.input_on};
            LMSC_OFF_MODE: st_next.rdata = {27'h0, st_reg.vrange, st_reg.mode};
            LMSC_OFF_SETPT: st_next.rdata = {16'h0, st_reg.setpt};
            LMSC_OFF_TRIG: st_next.rdata = {16'h0, st_reg.trig_lvl};
            LMSC_OFF_TRAN_HI: st_next.rdata = {16'h0, st_reg.tran_hi};
            LMSC_OFF_TRAN_LO: st_next.rdata = {16'h0, st_reg.tran_lo};
            LMSC_OFF_DWELL_HI: st_next.rdata = {15'h0, st_reg.dwell_hi};
            LMSC_OFF_DWELL_LO: st_next.rdata = {15'h0, st_reg.dwell_lo};
            LMSC_OFF_LIM: st_next.rdata = {16'h0, st_reg.lim};
            LMSC_OFF_LIM_DLY: st_next.rdata = {16'h0, st_reg.lim_dly};
            LMSC_OFF_STATUS: begin
               st_next.rdata = {26'h0, tran_act, st_reg.tran_phase, st_reg.alarm,
                                st_reg.trig_pend, st_reg.input_on, st_reg.remote};
            end
            LMSC_OFF_TARGET: st_next.rdata = {16'h0, st_reg.target};
            LMSC_OFF_IRQ_STAT: st_next.rdata = {28'h0, st_reg.irq_stat};
            LMSC_OFF_IRQ_MASK: st_next.rdata = {28'h0, st_reg.irq_mask};
            default: st_next.rdata = 32'h00000000;
         endcase
      end

      // front panel is only heard in local control
      if (panel_take) begin
         st_next = apply_write(st_next, panel_addr_i, panel_wdata_i);
      end

      // the lock/local key is the one key that still works in remote
      if (panel_lock_long_i && st_next.remote) begin
         st_next.remote = 1'b0;
         st_next.irq_stat[LMSC_EV_CTRL] = 1'b1;
      end

      // trigger promotes the armed level once; output follows via the target path
      if (trig_i && st_next.trig_pend) begin
         st_next.setpt = lmsc_clamp(st_next.trig_lvl, lmsc_min(st_next.mode, st_next.vrange),
                                    lmsc_max(st_next.mode, st_next.vrange));
         st_next.trig_pend = 1'b0;
         st_next.irq_stat[LMSC_EV_TRIG] = 1'b1;
      end

      // transient alternation; a zero dwell swaps on the next cycle
      if (!tran_act) begin
         st_next.tran_ms = 17'h00000;
         st_next.tran_phase = 1'b0;
      end else if (st_reg.tran_ms >= dwell_cur) begin
         st_next.tran_ms = 17'h00000;
         st_next.tran_phase = !st_reg.tran_phase;
      end else if (ms_tick) begin
         st_next.tran_ms = 17'(st_reg.tran_ms + 17'h00001);
      end

      // software current limit, counted in whole milliseconds over the limit
      if (!over_lim) begin
         st_next.lim_ms = 16'h0000;
      end else if (st_reg.lim_ms >= st_reg.lim_dly) begin
         st_next.input_on = 1'b0;
         st_next.alarm = 1'b1;
         st_next.irq_stat[LMSC_EV_TRIP] = 1'b1;
         st_next.lim_ms = 16'h0000;
      end else if (ms_tick) begin
         st_next.lim_ms = 16'(st_reg.lim_ms + 16'h0001);
      end

      // sink target follows the stored level one cycle after the input is on
      if (!st_reg.input_on) begin
         st_next.target = 16'h0000;
      end else if (lmsc_is_res(st_reg.mode)) begin
         st_next.target = cr_current(meas_volt_i, level_cur);
      end else begin
         st_next.target = level_cur;
      end
   end

   // state register; reset leaves the block local with the input off
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st_reg <= '{
            ack: 1'b0, rdata: 32'h00000000, remote: 1'b0, input_on: 1'b0,
            tran_en: 1'b0, mode: current_low_range, vrange: low_voltage_range,
            setpt: LMSC_SETPT_RST, trig_lvl: LMSC_SETPT_RST, trig_pend: 1'b0,
            tran_hi: LMSC_SETPT_RST, tran_lo: LMSC_SETPT_RST,
            dwell_hi: LMSC_DWELL_RST, dwell_lo: LMSC_DWELL_RST,
            lim: LMSC_LIM_RST, lim_dly: LMSC_LIM_DLY_RST, tran_phase: 1'b0,
            tran_ms: 17'h00000, lim_ms: 16'h0000, ms_div: 24'h000000, alarm: 1'b0,
            irq_stat: 4'h0, irq_mask: 4'h0, target: 16'h0000
         };
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign avs_readdata_o = st_reg.rdata;
   assign input_on_o = st_reg.input_on;
   assign sink_target_o = st_reg.target;
   assign remote_indicator_o = st_reg.remote;
   assign alarm_o = st_reg.alarm;
   assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_POWERUP_LOCAL: assert property (
      $rose(rst_b_i) |-> !remote_indicator_o && !input_on_o)
      else $error("block not local and off after reset");

   AST_REMOTE_ENTER: assert property (
      bus_wr_take && avs_address_i == LMSC_OFF_CMD && avs_writedata_i[LMSC_CMD_REMOTE_BIT]
      && !panel_lock_long_i |=> remote_indicator_o)
      else $error("remote command did not enter remote control");

   AST_PANEL_IGNORED: assert property (
      st_reg.remote && panel_wr_i && !bus_wr_take && !trig_i && !over_lim
      |=> $stable(st_reg.mode) && $stable(st_reg.setpt) && $stable(st_reg.input_on))
      else $error("panel write acted while in remote");

   AST_LOCAL_RETURN: assert property (
      panel_lock_long_i |=> !remote_indicator_o)
      else $error("long lock key did not return to local");

   AST_MODE_OFF: assert property (
      $changed({st_reg.mode, st_reg.vrange}) |-> !st_reg.input_on)
      else $error("input still on after mode change");

   AST_APPLY_ON: assert property (
      $rose(st_reg.input_on) && !lmsc_is_res(st_reg.mode) && !st_reg.tran_en
      |=> sink_target_o == $past(st_reg.setpt))
      else $error("set value not applied when input switched on");

   AST_CLAMP: assert property (
      st_reg.setpt >= lmsc_min(st_reg.mode, st_reg.vrange)
      && st_reg.setpt <= lmsc_max(st_reg.mode, st_reg.vrange))
      else $error("setpoint outside its range");

   AST_TRIG_APPLY: assert property (
      trig_i && st_reg.trig_pend && !bus_wr_take && !panel_take
      |=> !st_reg.trig_pend && st_reg.setpt == lmsc_clamp($past(st_reg.trig_lvl),
          lmsc_min($past(st_reg.mode), $past(st_reg.vrange)),
          lmsc_max($past(st_reg.mode), $past(st_reg.vrange))))
      else $error("trigger did not apply the triggered level");

   AST_TRIG_ONCE: assert property (
      trig_i && !st_reg.trig_pend && !bus_wr_take && !panel_take |=> $stable(st_reg.setpt))
      else $error("trigger acted without a new triggered level");

   AST_TRAN_SWAP: assert property (
      tran_act && st_reg.tran_ms >= dwell_cur |=> st_reg.tran_phase != $past(st_reg.tran_phase))
      else $error("transient level did not alternate after dwell");

   AST_TRIP: assert property (
      over_lim && st_reg.lim_ms >= st_reg.lim_dly |=> !input_on_o && alarm_o [*2])
      else $error("current limit did not trip input off with alarm");

endmodule

// [verif/lmsc_host_model.sv]
// lmsc_host_model: remote host issuing decoded serial commands as avalon-mm cycles
`timescale 1ns/100ps
module lmsc_host_model (
   // clock
   input wire logic sys_clk_i,
   // avalon-mm master side
   output logic [5:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [31:0] avs_writedata_o,
   input wire logic [31:0] avs_readdata_i,
   input wire logic avs_waitrequest_i
);
   logic hang = 1'b0;
   // idle bus at time zero
   initial begin
      avs_address_o = 6'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0;
   end
   // one cycle, held until waitrequest low; remote and local commands go this way
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= d;
      avs_write_o <= wr;
      avs_read_o <= !wr;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_i !== 1'b0 && n < 50);
      hang = (n >= 50);
      q = avs_readdata_i;
      // released lines show no stale value
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
      avs_writedata_o <= ~d;
   endtask
endmodule

// [verif/test_load_mode_setpoint_control.sv]
// test_load_mode_setpoint_control: table and directed checks of the setpoint control
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module test_load_mode_setpoint_control import lmsc_pkg::*;;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [5:0] adr, padr;
   logic rd_s, wr_s, pwr, plock, trig, wt, prdy, on, remote_indicator, alarm, irq;
   logic [31:0] wd, pwd, rdat, q;
   logic [15:0] mcur, mvolt, tgt;
   int failures = 0;
   int total_checks = 0;
   typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} lmsc_row_t;
   lmsc_row_t rows[6] = '{'{LMSC_OFF_SETPT, 32'h100, 32'h100},
      '{LMSC_OFF_SETPT, 32'hffff, 32'(LMSC_MAX_CUR_LO)},
      '{LMSC_OFF_LIM_DLY, 32'h0, 32'(LMSC_LIM_DLY_MIN_MS)},
      '{LMSC_OFF_LIM_DLY, 32'hffff, 32'(LMSC_LIM_DLY_MAX_MS)},
      '{LMSC_OFF_DWELL_HI, 32'h1ffff, 32'(LMSC_DWELL_MAX_MS)},
      '{6'h3c, 32'h5, 32'h0}};
   // clock, 100 ns period
   always #50 sys_clk_i = ~sys_clk_i;
   // short millisecond base keeps timed checks brief
   lmsc_top #(.MS_CYCLES(4)) u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .panel_wr_i(pwr), .panel_addr_i(padr),
      .panel_wdata_i(pwd), .panel_ready_o(prdy), .panel_lock_long_i(plock), .trig_i(trig),
      .meas_cur_i(mcur), .meas_volt_i(mvolt), .input_on_o(on), .sink_target_o(tgt),
      .remote_indicator_o(remote_indicator), .alarm_o(alarm), .irq_o(irq));
   lmsc_host_model u_host (.sys_clk_i(sys_clk_i), .avs_address_o(adr), .avs_read_o(rd_s),
      .avs_write_o(wr_s), .avs_writedata_o(wd), .avs_readdata_i(rdat), .avs_waitrequest_i(wt));
   task automatic give_verdict();
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // bus access; a hung bus closes the run
   task automatic bw(input logic [5:0] a, input logic [31:0] d, input logic rd = 1'b0);
      u_host.xfer(!rd, a, d, q);
      if (u_host.hang) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // one-cycle pulse on a panel or trigger line
   task automatic panel(input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      pwr <= 1'b1;
      padr <= a;
      pwd <= d;
      @(posedge sys_clk_i);
      `CHK("panel_ready", 1'b1, prdy)
      pwr <= 1'b0;
   endtask
   task automatic pulse_trig();
      @(posedge sys_clk_i);
      trig <= 1'b1;
      @(posedge sys_clk_i);
      trig <= 1'b0;
   endtask
   initial begin
      pwr = 1'b0;
      plock = 1'b0;
      trig = 1'b0;
      padr = 6'h00;
      pwd = 32'h0;
      mcur = 16'h0000;
      mvolt = 16'h0200;
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      cyc(1);
      `CHK("remote", 1'b0, remote_indicator)
      `CHK("input_on", 1'b0, on)
      foreach (rows[i]) begin
         bw(rows[i].a, rows[i].d);
         bw(rows[i].a, 32'h0, 1'b1);
         `CHK("readback", rows[i].e, q)
      end
      panel(LMSC_OFF_SETPT, 32'h123);
      bw(LMSC_OFF_SETPT, 32'h0, 1'b1);
      `CHK("panel setpt", 32'h123, q)
      bw(LMSC_OFF_CMD, 32'h1);
      cyc(1);
      `CHK("remote", 1'b1, remote_indicator)
      panel(LMSC_OFF_SETPT, 32'h45);
      bw(LMSC_OFF_SETPT, 32'h0, 1'b1);
      `CHK("setpt in remote", 32'h123, q)
      plock <= 1'b1;
      @(posedge sys_clk_i);
      plock <= 1'b0;
      cyc(1);
      `CHK("lock key", 1'b0, remote_indicator)
      bw(LMSC_OFF_CMD, 32'h1);
      bw(LMSC_OFF_CMD, 32'h2);
      cyc(1);
      `CHK("local cmd", 1'b0, remote_indicator)
      // range change with input on: off, setpoint refit, irq raised and cleared
      bw(LMSC_OFF_MODE, 32'h1);
      bw(LMSC_OFF_SETPT, 32'h1000);
      bw(LMSC_OFF_CTRL, 32'h1);
      cyc(2);
      `CHK("target", 16'h1000, tgt)
      bw(LMSC_OFF_IRQ_MASK, 32'h2);
      bw(LMSC_OFF_MODE, 32'h0);
      cyc(1);
      `CHK("forced off", 1'b0, on)
      `CHK("irq", 1'b1, irq)
      bw(LMSC_OFF_SETPT, 32'h0, 1'b1);
      `CHK("refit", 32'(LMSC_MAX_CUR_LO), q)
      bw(LMSC_OFF_IRQ_STAT, 32'h2);
      cyc(1);
      `CHK("irq clear", 1'b0, irq)
      // trigger applies once, then is ignored until a new level
      bw(LMSC_OFF_TRIG, 32'h200);
      bw(LMSC_OFF_STATUS, 32'h0, 1'b1);
      `CHK("pending", 1'b1, q[2])
      pulse_trig();
      bw(LMSC_OFF_SETPT, 32'h0, 1'b1);
      `CHK("trig level", 32'h200, q)
      bw(LMSC_OFF_SETPT, 32'h50);
      pulse_trig();
      bw(LMSC_OFF_SETPT, 32'h0, 1'b1);
      `CHK("second trig", 32'h50, q)
      // transient alternates lower and upper levels, 1 ms dwell each
      bw(LMSC_OFF_TRAN_HI, 32'h300);
      bw(LMSC_OFF_TRAN_LO, 32'h100);
      bw(LMSC_OFF_DWELL_HI, 32'h1);
      bw(LMSC_OFF_CTRL, 32'h3);
      for (int n = 0; n < 40 && tgt !== 16'h0300; n++) cyc(1);
      `CHK("tran upper", 16'h0300, tgt)
      for (int n = 0; n < 40 && tgt !== 16'h0100; n++) cyc(1);
      `CHK("tran lower", 16'h0100, tgt)
      // resistance mode sinks v over r scaled by 256: 0x200 over 0x100 gives 0x200
      bw(LMSC_OFF_CTRL, 32'h0);
      bw(LMSC_OFF_MODE, 32'h4);
      bw(LMSC_OFF_SETPT, 32'h100);
      bw(LMSC_OFF_CTRL, 32'h1);
      cyc(2);
      `CHK("cr target", 16'h0200, tgt)
      // overcurrent beyond a 1 ms delay trips the input
      bw(LMSC_OFF_LIM_DLY, 32'h1);
      bw(LMSC_OFF_LIM, 32'h10);
      bw(LMSC_OFF_CTRL, 32'h1);
      mcur <= 16'h0020;
      for (int n = 0; n < 40 && alarm !== 1'b1; n++) cyc(1);
      `CHK("alarm", 1'b1, alarm)
      `CHK("trip off", 1'b0, on)
      // reset in mid-run from remote with the alarm up
      bw(LMSC_OFF_CMD, 32'h1);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      cyc(1);
      `CHK("reset remote", 1'b0, remote_indicator)
      `CHK("reset alarm", 1'b0, alarm)
      `CHK("reset on", 1'b0, on)
      `CHK("reset target", 16'h0000, tgt)
      give_verdict();
   end
endmodule
